// *** hw/iffb_pkg.sv ***
// Constants shared by the event, queue and burst logic of the serial controller
package iffb_pkg;
    // ==========================================
    // Register byte offsets
    localparam logic [11:0] OFS_MCS   = 12'h004;
    localparam logic [11:0] OFS_MIMR  = 12'h010;
    localparam logic [11:0] OFS_MRIS  = 12'h014;
    localparam logic [11:0] OFS_MMIS  = 12'h018;
    localparam logic [11:0] OFS_MICR  = 12'h01c;
    localparam logic [11:0] OFS_MCR   = 12'h020;
    localparam logic [11:0] OFS_BLEN  = 12'h030;
    localparam logic [11:0] OFS_BCNT  = 12'h034;
    localparam logic [11:0] OFS_SCSR  = 12'h804;
    localparam logic [11:0] OFS_SIMR  = 12'h80c;
    localparam logic [11:0] OFS_SRIS  = 12'h810;
    localparam logic [11:0] OFS_SMIS  = 12'h814;
    localparam logic [11:0] OFS_SICR  = 12'h818;
    localparam logic [11:0] OFS_QDATA = 12'hf00;
    localparam logic [11:0] OFS_QCTL  = 12'hf04;
    localparam logic [11:0] OFS_QSTAT = 12'hf08;
    // ==========================================
    // Event bit positions, same layout in both engines
    localparam int EV_W       = 12;
    localparam int EV_DONE    = 0;
    localparam int EV_TMO     = 1;
    localparam int EV_DMARX   = 2;
    localparam int EV_DMATX   = 3;
    localparam int EV_NACK    = 4;
    localparam int EV_START   = 5;
    localparam int EV_STOP    = 6;
    localparam int EV_ARB     = 7;
    localparam int EV_TXTHR   = 8;
    localparam int EV_RXTHR   = 9;
    localparam int EV_TXEMPTY = 10;
    localparam int EV_RXFULL  = 11;
    // ==========================================
    // Control fields
    localparam int MCS_RUN    = 0;
    localparam int MCS_STOP   = 2;
    localparam int MCS_BURST  = 6;
    localparam int MCS_RX     = 7;
    localparam int MCR_LOOPBACK_SELECT   = 0;
    localparam int MCR_DMA    = 1;
    localparam int SCSR_TXUSE = 2;
    localparam int SCSR_RXUSE = 3;
    localparam int QC_TXTHR   = 0;
    localparam int QC_TXOWN   = 15;
    localparam int QC_RXTHR   = 16;
    localparam int QC_RXOWN   = 31;
    localparam int QS_RX      = 16;
    // ==========================================
    // Sizes and reset values
    localparam int QUEUE_DEPTH = 8;
    localparam int LVL_W       = 4;
    localparam int BLEN_WIDTH  = 8;
    localparam logic [LVL_W-1:0] SHORT_BURST = 4'h4;
    localparam logic [EV_W-1:0]  MASK_RST    = 12'h000;
    localparam logic [3:0]       VIEW_RST    = 4'h5;
endpackage

// *** hw/iffb_top.sv ***
// Event, loopback, byte queue and burst logic of a two-engine serial bus controller
`timescale 1ns/1ps
`default_nettype none

module iffb_top
    import iffb_pkg::*;
#(
    parameter int Q_DEPTH = QUEUE_DEPTH,
    parameter int BLEN_W  = BLEN_WIDTH
)
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             scl_o,
    output logic             scl_oe,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic        mst_scl_oe,
    input  wire logic        mst_sda_oe,
    input  wire logic        slv_scl_oe,
    input  wire logic        slv_sda_oe,
    output logic             line_scl,
    output logic             line_sda,
    input  wire logic        mst_done,
    input  wire logic        mst_next_req,
    input  wire logic        mst_arb_lost,
    input  wire logic        mst_nack_addr,
    input  wire logic        mst_nack_data,
    input  wire logic        mst_timeout,
    input  wire logic        mst_byte_tx,
    input  wire logic        mst_byte_rx,
    input  wire logic [7:0]  mst_rx_data,
    input  wire logic        slv_data_req,
    input  wire logic        slv_next_req,
    input  wire logic        slv_byte_tx,
    input  wire logic        slv_byte_rx,
    input  wire logic [7:0]  slv_rx_data,
    output logic [7:0]       tx_head,
    output logic             mst_tx_avail,
    output logic             slv_tx_avail,
    output logic             mst_rx_room,
    output logic             slv_rx_room,
    output logic             mst_stop_req,
    output logic             mst_event,
    output logic             slv_event,
    input  wire logic        mst_dma_tx_done,
    input  wire logic        mst_dma_rx_done,
    input  wire logic        slv_dma_tx_done,
    input  wire logic        slv_dma_rx_done,
    output logic             mst_tx_sreq,
    output logic             mst_tx_req,
    output logic             mst_rx_sreq,
    output logic             mst_rx_req,
    output logic             slv_tx_sreq,
    output logic             slv_tx_req,
    output logic             slv_rx_sreq,
    output logic             slv_rx_req
);
    localparam int PTR_W = $clog2(Q_DEPTH);
    localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(Q_DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(Q_DEPTH - 1);

    // ==========================================
    // Bus slave
    logic             wr_pend_r;
    logic [11:0]      waddr_r;
    logic             rd_acc;
    logic             wr_act;
    logic [31:0]      rd_val;
    logic [31:0]      hrdata_r;

    assign rd_acc    = hsel && hready && htrans[1] && !hwrite;
    assign wr_act    = wr_pend_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            {wr_pend_r, waddr_r, hrdata_r} <= '0;
        else
        begin
            wr_pend_r <= hsel && hready && htrans[1] && hwrite;
            waddr_r   <= haddr[11:0];
            if (rd_acc)
                hrdata_r <= rd_val;
        end
    end

    // ==========================================
    // Control registers
    logic [EV_W-1:0]  m_mask_r;
    logic [EV_W-1:0]  s_mask_r;
    logic [1:0]       mcr_r;
    logic [3:0]       scsr_r;
    logic [31:0]      qctl_r;
    logic             mcs_stop_r;
    logic             mcs_rx_r;
    logic [BLEN_W-1:0] blen_r;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            {m_mask_r, s_mask_r}           <= {MASK_RST, MASK_RST};
            {mcr_r, scsr_r, qctl_r}        <= '0;
            {mcs_stop_r, mcs_rx_r, blen_r} <= '0;
        end
        else if (wr_act)
            case (waddr_r)
                OFS_MIMR: m_mask_r <= hwdata[EV_W-1:0];
                OFS_SIMR: s_mask_r <= hwdata[EV_W-1:0];
                OFS_MCR:  mcr_r    <= hwdata[1:0];
                OFS_SCSR: scsr_r   <= hwdata[3:0];
                OFS_QCTL: qctl_r   <= hwdata;
                OFS_BLEN: blen_r   <= hwdata[BLEN_W-1:0];
                OFS_MCS:  {mcs_stop_r, mcs_rx_r} <= {hwdata[MCS_STOP], hwdata[MCS_RX]};
                default: ;
            endcase
    end

    logic [LVL_W-1:0] tx_thr;
    logic [LVL_W-1:0] rx_thr;
    logic             tx_slave;
    logic             rx_slave;
    assign tx_thr   = qctl_r[QC_TXTHR +: LVL_W];
    assign rx_thr   = qctl_r[QC_RXTHR +: LVL_W];
    assign tx_slave = qctl_r[QC_TXOWN];
    assign rx_slave = qctl_r[QC_RXOWN];

    // ==========================================
    // Transmit and receive queues
    logic [7:0]       tx_mem [Q_DEPTH];
    logic [7:0]       rx_mem [Q_DEPTH];
    logic [PTR_W-1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
    logic [LVL_W-1:0] tx_lvl_r, rx_lvl_r;
    logic             tx_push, tx_pop, rx_push, rx_pop;
    logic [7:0]       rx_in;

    // Transmit pops and receive pushes follow the owner only; the other engine is ignored.
    assign tx_push = wr_act && waddr_r == OFS_QDATA && tx_lvl_r != FULL_LVL;
    assign tx_pop  = (tx_slave ? slv_byte_tx : mst_byte_tx) && tx_lvl_r != '0;
    assign rx_push = (rx_slave ? slv_byte_rx : mst_byte_rx) && rx_lvl_r != FULL_LVL;
    assign rx_in   = rx_slave ? slv_rx_data : mst_rx_data;
    assign rx_pop  = rd_acc && haddr[11:0] == OFS_QDATA && rx_lvl_r != '0;
    assign tx_head = tx_mem[tx_rp_r];

    always_ff @(posedge sys_clk)
    begin
        if (tx_push)
            tx_mem[tx_wp_r] <= hwdata[7:0];
        if (rx_push)
            rx_mem[rx_wp_r] <= rx_in;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            {tx_wp_r, tx_rp_r, tx_lvl_r, rx_wp_r, rx_rp_r, rx_lvl_r} <= '0;
        else
        begin
            if (tx_push)
                tx_wp_r <= (tx_wp_r == LAST_PTR) ? '0 : tx_wp_r + 1'b1;
            if (tx_pop)
                tx_rp_r <= (tx_rp_r == LAST_PTR) ? '0 : tx_rp_r + 1'b1;
            if (tx_push && !tx_pop)
                tx_lvl_r <= tx_lvl_r + 1'b1;
            else if (tx_pop && !tx_push)
                tx_lvl_r <= tx_lvl_r - 1'b1;
            if (rx_push)
                rx_wp_r <= (rx_wp_r == LAST_PTR) ? '0 : rx_wp_r + 1'b1;
            if (rx_pop)
                rx_rp_r <= (rx_rp_r == LAST_PTR) ? '0 : rx_rp_r + 1'b1;
            if (rx_push && !rx_pop)
                rx_lvl_r <= rx_lvl_r + 1'b1;
            else if (rx_pop && !rx_push)
                rx_lvl_r <= rx_lvl_r - 1'b1;
        end
    end

    // Per-engine view; a non-owner sees an empty queue.
    logic [LVL_W-1:0] m_tx_lvl, s_tx_lvl, m_rx_lvl, s_rx_lvl;
    assign m_tx_lvl     = tx_slave ? '0 : tx_lvl_r;
    assign s_tx_lvl     = tx_slave ? tx_lvl_r : '0;
    assign m_rx_lvl     = rx_slave ? '0 : rx_lvl_r;
    assign s_rx_lvl     = rx_slave ? rx_lvl_r : '0;
    assign mst_tx_avail = m_tx_lvl != '0;
    assign slv_tx_avail = s_tx_lvl != '0;
    assign mst_rx_room  = m_rx_lvl != FULL_LVL;
    assign slv_rx_room  = s_rx_lvl != FULL_LVL;

    // View bits: rx full, tx empty, rx threshold, tx threshold
    logic [3:0] m_view, s_view, m_view_r, s_view_r;
    assign m_view = {m_rx_lvl == FULL_LVL, m_tx_lvl == '0, m_rx_lvl > rx_thr, m_tx_lvl <= tx_thr};
    assign s_view = {s_rx_lvl == FULL_LVL, s_tx_lvl == '0, s_rx_lvl > rx_thr, s_tx_lvl <= tx_thr};

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            {m_view_r, s_view_r} <= {VIEW_RST, VIEW_RST};
        else
            {m_view_r, s_view_r} <= {m_view, s_view};
    end

    // ==========================================
    // Bus lines, pin synchroniser and loopback
    logic [2:0] scl_sy_r, sda_sy_r;
    logic       scl_st_r, sda_st_r, scl_prev_r, sda_prev_r;
    logic       loopback_select, start_det, stop_det;
    assign loopback_select = mcr_r[MCR_LOOPBACK_SELECT];
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            {scl_sy_r, sda_sy_r}                         <= 6'h3f;
            {scl_st_r, sda_st_r, scl_prev_r, sda_prev_r} <= 4'hf;
            {scl_oe, sda_oe}                             <= 2'h0;
        end
        else
        begin
            scl_sy_r <= {scl_sy_r[1:0], scl_i};
            sda_sy_r <= {sda_sy_r[1:0], sda_i};
            if (scl_sy_r[1] == scl_sy_r[2])
                scl_st_r <= scl_sy_r[2];
            if (sda_sy_r[1] == sda_sy_r[2])
                sda_st_r <= sda_sy_r[2];
            scl_prev_r <= line_scl;
            sda_prev_r <= line_sda;
            // Pins released while the engines talk to each other.
            scl_oe <= !loopback_select && (mst_scl_oe || slv_scl_oe);
            sda_oe <= !loopback_select && (mst_sda_oe || slv_sda_oe);
        end
    end

    assign line_scl  = loopback_select ? !(mst_scl_oe || slv_scl_oe) : scl_st_r;
    assign line_sda  = loopback_select ? !(mst_sda_oe || slv_sda_oe) : sda_st_r;
    assign start_det = line_scl && scl_prev_r && sda_prev_r && !line_sda;
    assign stop_det  = line_scl && scl_prev_r && !sda_prev_r && line_sda;

    // ==========================================
    // Burst control
    logic              burst_go, burst_act_r, byte_done;
    logic [BLEN_W-1:0] bcnt_r, fed_r;
    assign burst_go  = wr_act && waddr_r == OFS_MCS && hwdata[MCS_BURST] && hwdata[MCS_RUN];
    assign byte_done = mst_byte_tx || mst_byte_rx;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            {burst_act_r, bcnt_r, fed_r, mst_stop_req} <= '0;
        else
        begin
            mst_stop_req <= burst_act_r && (mst_nack_addr || (mst_nack_data && mcs_stop_r));
            if (burst_go)
            begin
                burst_act_r <= 1'b1;
                bcnt_r      <= blen_r;
                fed_r       <= blen_r;
            end
            else
            begin
                // A nack ends the burst; a byte done in the same cycle still counts down.
                if (burst_act_r && (mst_nack_addr || mst_nack_data))
                    burst_act_r <= 1'b0;
                else if (burst_act_r && byte_done && bcnt_r <= 1)
                    burst_act_r <= 1'b0;
                if (burst_act_r && byte_done && bcnt_r != '0)
                    bcnt_r <= bcnt_r - 1'b1;
                if (burst_act_r && !mcs_rx_r && tx_push && fed_r != '0)
                    fed_r <= fed_r - 1'b1;
            end
        end
    end

    // ==========================================
    // DMA requests
    logic m_tx_dma, s_tx_dma, s_rx_dma;
    assign m_tx_dma = burst_act_r && mcr_r[MCR_DMA] && !mcs_rx_r && !tx_slave && fed_r != '0;
    assign s_tx_dma = tx_slave && scsr_r[SCSR_TXUSE];
    assign s_rx_dma = rx_slave && scsr_r[SCSR_RXUSE];

    assign mst_tx_sreq = m_tx_dma && tx_lvl_r != FULL_LVL;
    assign mst_tx_req  = m_tx_dma && fed_r < BLEN_W'(SHORT_BURST)
                         && tx_lvl_r < tx_thr;
    assign mst_rx_sreq = mcr_r[MCR_DMA] && mcs_rx_r && m_rx_lvl != '0;
    assign mst_rx_req  = mcr_r[MCR_DMA] && mcs_rx_r && m_rx_lvl > rx_thr;
    assign slv_tx_sreq = s_tx_dma && slv_next_req;
    assign slv_tx_req  = s_tx_dma && s_tx_lvl < tx_thr;
    assign slv_rx_sreq = s_rx_dma && s_rx_lvl != '0;
    assign slv_rx_req  = s_rx_dma && s_rx_lvl > rx_thr;

    // ==========================================
    // Event registers
    logic [EV_W-1:0] m_set, s_set, m_clr, s_clr, m_raw_r, s_raw_r;

    always_comb
    begin
        m_set             = '0;
        m_set[EV_DONE]    = mst_done || mst_next_req;
        m_set[EV_TMO]     = mst_timeout;
        m_set[EV_DMATX:EV_DMARX] = {mst_dma_tx_done, mst_dma_rx_done};
        m_set[EV_NACK]    = mst_nack_addr || mst_nack_data;
        m_set[EV_START]   = start_det;
        m_set[EV_STOP]    = stop_det;
        m_set[EV_ARB]     = mst_arb_lost;
        // Edge-set, so clearing while empty does not refire.
        m_set[EV_RXFULL:EV_TXTHR] = m_view & ~m_view_r;
        s_set             = '0;
        s_set[EV_DONE]    = slv_byte_rx || slv_data_req || slv_next_req;
        s_set[EV_DMATX:EV_DMARX] = {slv_dma_tx_done, slv_dma_rx_done};
        s_set[EV_START]   = start_det;
        s_set[EV_STOP]    = stop_det;
        s_set[EV_RXFULL:EV_TXTHR] = s_view & ~s_view_r;
    end

    assign m_clr = (wr_act && waddr_r == OFS_MICR) ? hwdata[EV_W-1:0] : '0;
    assign s_clr = (wr_act && waddr_r == OFS_SICR) ? hwdata[EV_W-1:0] : '0;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            {m_raw_r, s_raw_r} <= '0;
        else
        begin
            // Set wins over a clear in the same cycle
            m_raw_r <= (m_raw_r & ~m_clr) | m_set;
            s_raw_r <= (s_raw_r & ~s_clr) | s_set;
        end
    end

    assign mst_event = |(m_raw_r & m_mask_r);
    assign slv_event = |(s_raw_r & s_mask_r);

    // ==========================================
    // Read mux
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (haddr[11:0])
            OFS_MCS:
            begin
                rd_val[MCS_RUN]  = burst_act_r;
                rd_val[MCS_STOP] = mcs_stop_r;
                rd_val[MCS_RX]   = mcs_rx_r;
            end
            OFS_MIMR:  rd_val[EV_W-1:0] = m_mask_r;
            OFS_MRIS:  rd_val[EV_W-1:0] = m_raw_r;
            OFS_MMIS:  rd_val[EV_W-1:0] = m_raw_r & m_mask_r;
            OFS_MCR:   rd_val[1:0] = mcr_r;
            OFS_BLEN:  rd_val[BLEN_W-1:0] = blen_r;
            OFS_BCNT:  rd_val[BLEN_W-1:0] = bcnt_r;
            OFS_SCSR:  rd_val[3:0] = scsr_r;
            OFS_SIMR:  rd_val[EV_W-1:0] = s_mask_r;
            OFS_SRIS:  rd_val[EV_W-1:0] = s_raw_r;
            OFS_SMIS:  rd_val[EV_W-1:0] = s_raw_r & s_mask_r;
            OFS_QDATA: rd_val[7:0] = (rx_lvl_r != '0) ? rx_mem[rx_rp_r] : 8'h00;
            OFS_QCTL:  rd_val = qctl_r;
            OFS_QSTAT: {rd_val[QS_RX +: LVL_W], rd_val[LVL_W-1:0]} = {rx_lvl_r, tx_lvl_r};
            default:   rd_val = 32'h0000_0000;
        endcase
    end
endmodule

`default_nettype wire

// *** testbench/iffb_top_properties.sv ***
// Port checks on the event, queue and burst block
`timescale 1ns/1ps
`default_nettype none
module iffb_top_properties (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic mst_nack_addr,
    input wire logic mst_nack_data,
    input wire logic mst_tx_avail,
    input wire logic slv_tx_avail,
    input wire logic mst_rx_room,
    input wire logic slv_rx_room,
    input wire logic mst_stop_req,
    input wire logic mst_tx_sreq,
    input wire logic mst_tx_req,
    input wire logic mst_rx_sreq,
    input wire logic mst_rx_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_tx_owner_one: assert property (!(mst_tx_avail && slv_tx_avail))
        else $error("tx queue seen by both engines");
    a_rx_room_owner: assert property (mst_rx_room || slv_rx_room)
        else $error("rx queue full for both engines");
    a_tx_multi_single: assert property (mst_tx_req |-> mst_tx_sreq)
        else $error("tx multi request without single");
    a_rx_multi_single: assert property (mst_rx_req |-> mst_rx_sreq)
        else $error("rx multi request without single");
    a_stop_one_cycle: assert property (mst_stop_req |=> !mst_stop_req)
        else $error("stop request longer than a cycle");
    a_stop_after_nack: assert property (mst_stop_req |-> $past(mst_nack_addr || mst_nack_data))
        else $error("stop request without nack");
    a_tx_sreq_owner: assert property (mst_tx_sreq |-> !slv_tx_avail)
        else $error("master request on slave queue");
    a_addr_nack_stop: assert property (mst_nack_addr && mst_tx_sreq |=> mst_stop_req)
        else $error("no stop after address nack");
endmodule
`default_nettype wire

// *** testbench/iffb_peer.sv ***
// Far-side bus device and DMA controller model
`timescale 1ns/1ps
`default_nettype none
module iffb_peer (
    input  wire logic       sys_clk,
    input  wire logic       go,
    input  wire logic [3:0] dma_go,
    input  wire logic       scl_oe,
    input  wire logic       sda_oe,
    output logic            scl_i,
    output logic            sda_i,
    output logic [3:0]      dma_done
);
    logic clk_r = 1'b1;
    logic dat_r = 1'b1;
    int   k;
    // Pull-ups: a released line reads high
    assign scl_i = clk_r & ~scl_oe;
    assign sda_i = dat_r & ~sda_oe;
    initial dma_done = 4'h0;
    always @(posedge sys_clk)
        dma_done <= dma_go;
    // Clock runs only inside a frame, 80 ns a bit
    always @(posedge go)
    begin
        // Keep line edges clear of the sampling clock edge
        #2;
        dat_r = 1'b0;
        #40;
        for (k = 0; k < 9; k++)
        begin
            clk_r = 1'b0;
            #20 dat_r = k[0];
            #20 clk_r = 1'b1;
            #40;
        end
        clk_r = 1'b0;
        #20 dat_r = 1'b0;
        #20 clk_r = 1'b1;
        #20 dat_r = 1'b1;
    end
endmodule
`default_nettype wire

// *** testbench/iffb_top_tb.sv ***
// Self-checking bench for the event, queue and burst block
`timescale 1ns/1ps
`default_nettype none
module iffb_top_tb;
    import iffb_pkg::*;
    logic sys_clk = 0, rstn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, go = 0, rd_dp = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic scl_i, sda_i, scl_o, scl_oe, sda_o, sda_oe, line_scl, line_sda, mst_event, slv_event;
    logic mst_scl_oe = 0, mst_sda_oe = 0, slv_scl_oe = 0, slv_sda_oe = 0;
    logic slv_byte_tx = 0, slv_byte_rx, mst_byte_tx, mst_byte_rx, mst_nack_data, mst_nack_addr;
    logic mst_done, mst_arb_lost, mst_timeout, mst_next_req, slv_data_req, slv_next_req;
    logic [10:0] pv = 0;
    logic [7:0] rxd = 0, lf = 8'h51, tx_head, mst_rx_data, slv_rx_data;
    logic mst_tx_avail, slv_tx_avail, mst_rx_room, slv_rx_room, mst_stop_req;
    logic mst_tx_sreq, mst_tx_req, mst_rx_sreq, mst_rx_req, slv_tx_sreq, slv_tx_req, slv_rx_sreq;
    logic slv_rx_req, mst_dma_tx_done, mst_dma_rx_done, slv_dma_tx_done, slv_dma_rx_done;
    logic [3:0] dma_go = 0;
    logic [63:0] t;
    logic [63:0] q[$];
    logic [7:0] e[$];
    int error_cnt = 0, comparisons = 0, cyc = 0, rises = 0, n, b;
    int eb[7] = '{EV_DONE, EV_ARB, EV_TMO, EV_DONE, EV_NACK, EV_DONE, EV_DONE};
    assign hready = hreadyout;
    assign {slv_byte_rx, mst_byte_rx, mst_byte_tx, mst_nack_data, slv_next_req, slv_data_req,
            mst_nack_addr, mst_next_req, mst_timeout, mst_arb_lost, mst_done} = pv;
    assign mst_rx_data = rxd;
    assign slv_rx_data = rxd;
    iffb_top iffb_top_inst (.*);
    iffb_peer iffb_peer_inst (.sys_clk, .go, .dma_go, .scl_oe, .sda_oe, .scl_i, .sda_i,
        .dma_done({mst_dma_tx_done, mst_dma_rx_done, slv_dma_tx_done, slv_dma_rx_done}));
    always #5 sys_clk = ~sys_clk;
    always @(posedge line_scl) rises++;
    function automatic logic [7:0] nx(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge sys_clk); while (!hready);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !w;
        do @(posedge sys_clk); while (!hready);
        rd_dp <= 0;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] x, logic [31:0] m);
        q.push_back({m, x});
        bus(0, a, 0);
    endtask
    task automatic pls(int i);
        @(posedge sys_clk);
        pv <= 11'h1 << i;
        rxd <= lf;
        @(posedge sys_clk);
        pv <= 0;
        @(negedge sys_clk);
    endtask
    // Result watcher: the oldest note is matched against each read answer
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            final_report();
        end
        if (rd_dp && hready)
        begin
            t = q.pop_front();
            chk(hrdata & t[63:32], t[31:0]);
        end
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1;
        rd(OFS_MIMR, 0, '1);
        rd(OFS_BCNT, 0, '1);
        rd(12'h0fc, 0, '1);
        for (n = 0; n < 7; n++)
        begin
            b = eb[n];
            bus(1, n > 4 ? OFS_SIMR : OFS_MIMR, n[0] << b);
            pls(n);
            chk(n > 4 ? slv_event : mst_event, n[0]);
            rd(n > 4 ? OFS_SRIS : OFS_MRIS, 1 << b, 1 << b);
            bus(1, n > 4 ? OFS_SICR : OFS_MICR, 1 << b);
            rd(n > 4 ? OFS_SRIS : OFS_MRIS, 0, 1 << b);
        end
        for (n = 0; n < 9; n++)
        begin
            if (n < 8)
                e.push_back(lf);
            bus(1, OFS_QDATA, {24'h0, lf});
            lf = nx(lf);
        end
        rd(OFS_QSTAT, 8, 32'hf);
        for (n = 0; n < 8; n++)
        begin
            chk(tx_head, e.pop_front());
            pls(8);
        end
        bus(1, OFS_MICR, 1 << EV_TXEMPTY);
        rd(OFS_MRIS, 0, 1 << EV_TXEMPTY);
        bus(1, OFS_QCTL, 32'h0001_0002);
        for (n = 0; n < 8; n++)
        begin
            e.push_back(lf);
            pls(9);
            lf = nx(lf);
        end
        chk(mst_rx_room, 0);
        bus(1, OFS_MCR, 2);
        bus(1, OFS_MCS, 32'h80);
        @(negedge sys_clk);
        chk({mst_rx_sreq, mst_rx_req}, 2'b11);
        for (n = 0; n < 8; n++)
            rd(OFS_QDATA, e.pop_front(), 32'hff);
        chk(mst_rx_sreq, 0);
        bus(1, OFS_SCSR, 32'hc);
        bus(1, OFS_QCTL, 32'h8001_8002);
        pls(10);
        chk({slv_tx_req, slv_tx_sreq}, 2'b10);
        chk({slv_rx_sreq, slv_rx_req}, 2'b10);
        chk({mst_rx_sreq, mst_rx_room, slv_rx_room}, 3'b011);
        rd(OFS_QDATA, lf, 32'hff);
        bus(1, OFS_QCTL, 32'h0001_0002);
        bus(1, OFS_BLEN, 3);
        bus(1, OFS_MCR, 2);
        bus(1, OFS_MCS, 32'h41);
        rd(OFS_BCNT, 3, '1);
        chk({mst_tx_sreq, mst_tx_req}, 2'b11);
        repeat (2) bus(1, OFS_QDATA, lf);
        pls(8);
        pls(4);
        rd(OFS_BCNT, 2, '1);
        bus(1, OFS_MCS, 32'h41);
        repeat (3) bus(1, OFS_QDATA, lf);
        @(negedge sys_clk);
        chk(mst_tx_sreq, 0);
        @(posedge sys_clk);
        dma_go <= 4'hc;
        @(posedge sys_clk);
        dma_go <= 4'h0;
        rd(OFS_MRIS, 12'h00c, 12'h00c);
        bus(1, OFS_MCR, 1);
        mst_sda_oe <= 1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk({line_sda, sda_oe}, 0);
        bus(1, OFS_MCR, 0);
        mst_sda_oe <= 0;
        // Drop the start and stop left by the loopback test
        bus(1, OFS_MICR, 3 << EV_START);
        bus(1, OFS_SICR, 3 << EV_START);
        rises = 0;
        go <= 1;
        repeat (100) @(posedge sys_clk);
        go <= 0;
        chk(rises, 10);
        rd(OFS_MRIS, 3 << EV_START, 3 << EV_START);
        rd(OFS_SRIS, 3 << EV_START, 3 << EV_START);
        final_report();
    end
endmodule
bind iffb_top iffb_top_properties iffb_top_properties_inst (.*);
`default_nettype wire
